/* File: dmaa_channel_addr.sv */
// Per-channel DMA address generation, autoinit reload and stop limit
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Per-channel bit selects autoinitialization
// - Terminal count reloads current from base on autoinit channels
// - Current writes also load base registers
// - Autoinit channel not masked at terminal count, restarts unaided
// - Slave decode; ISA limited; answer interrupt acknowledge
// - ISA grant closes two register ranges
// - Master mode runs DMA or refresh
// - 22-bit stop value, enable per channel
// - End of process on an autoinit channel reloads address from base
// - Mask after first stop-matching address
// - Stop compares address bits 23 to 2
// - Recovery between back-to-back host accesses
// - Low page register, restored on autoinit
// - High page register, restored on autoinit
// - Low address bytes clear high page
// - High page written last: extended mode
// - Compatibility mode never carries into pages
// - Extended mode: memory commands below 16M
// - Reset, master clear restore compatibility mode
// - Terminal count on zero to all ones
module dmaa_channel_addr (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic master_clear,
  // Register access from the system bus
  input var dmaa_pkg::dmaa_io_req_type io_req,
  output logic io_ready,
  output logic io_hit,
  output logic [7:0] io_rdata,
  // Bus role and cycles
  input wire logic isa_grant,
  input wire logic arb_master,
  input wire logic refresh_cycle,
  input wire logic inta_cycle,
  output logic inta_ack,
  output logic bus_owned,
  output logic refresh_active,
  // Transfer requests
  input wire logic xfer_go,
  input wire logic [2:0] xfer_chan,
  input wire logic end_of_process_marker,
  // Transfer results
  output dmaa_pkg::dmaa_xfer_type xfer_out,
  output logic [7:0] mask_set,
  output logic [7:0] ext_mode
);

  localparam int NC = dmaa_pkg::NUM_CHAN;

  // Current and base registers per channel
  logic [15:0] cur_addr_reg [NC];
  logic [15:0] base_addr_reg [NC];
  logic [23:0] cur_cnt_reg [NC];
  logic [23:0] base_cnt_reg [NC];
  logic [7:0] cur_lpage_reg [NC];
  logic [7:0] base_lpage_reg [NC];
  logic [7:0] cur_hpage_reg [NC];
  logic [7:0] base_hpage_reg [NC];
  // Stop value and configuration
  logic [21:0] stop_reg [NC];
  logic [7:0] cfg_reg [NC];
  // Address mode flip-flop per channel, one means extended
  logic [7:0] ext_mode_reg;
  // Channels halted by a stop match
  logic [7:0] stopped_reg;
  // Recovery counter for host accesses
  logic [3:0] recov_reg;
  // Registered outputs
  dmaa_pkg::dmaa_xfer_type xfer_reg;
  logic [7:0] mask_reg;
  logic [7:0] rdata_reg;

  // Decoded access
  logic in_window;
  logic isa_closed;
  logic [2:0] acc_chan;
  logic [3:0] acc_fld;
  logic acc_wr;
  logic acc_rd;

  // Full 32-bit address of a channel
  function automatic logic [31:0] full_addr(input logic [7:0] hp,
                                            input logic [7:0] lp,
                                            input logic [15:0] ca);
    full_addr = {hp, lp, ca};
  endfunction : full_addr

  // Next address after one transfer
  function automatic logic [31:0] step_addr(input logic [31:0] a,
                                            input logic decr,
                                            input logic [1:0] size,
                                            input logic ext);
    logic [31:0] delta;
    logic [31:0] moved;
    delta = 32'h00000001;
    moved = 32'h00000000;
    if (size == dmaa_pkg::SIZE_WORD) begin
      delta = 32'h00000002;
    end else if (size == dmaa_pkg::SIZE_DWORD) begin
      delta = 32'h00000004;
    end
    moved = decr ? (a - delta) : (a + delta);
    if (ext) begin
      step_addr = moved;
    end else begin
      step_addr = {a[31:16], moved[15:0]};
    end
  endfunction : step_addr

  // Address decode, ISA exclusion and recovery
  always_comb begin
    in_window = (io_req.addr[15:8] == dmaa_pkg::REG_BASE[15:8]) &&
                (io_req.addr[7] == 1'b0);
    acc_chan = io_req.addr[6:4];
    acc_fld = io_req.addr[3:0];
    isa_closed = (io_req.src == dmaa_pkg::SRC_ISA) && isa_grant &&
      (((io_req.addr >= dmaa_pkg::ISA_CLOSED0_LO) &&
        (io_req.addr <= dmaa_pkg::ISA_CLOSED0_HI)) ||
       ((io_req.addr >= dmaa_pkg::ISA_CLOSED1_LO) &&
        (io_req.addr <= dmaa_pkg::ISA_CLOSED1_HI)));
    io_hit = in_window && !arb_master && !isa_closed &&
             (acc_fld <= dmaa_pkg::FLD_CFG);
    acc_wr = io_hit && io_req.wr && io_ready;
    acc_rd = io_hit && io_req.rd && io_ready;
  end

  // Ready whenever no recovery is pending
  assign io_ready = (recov_reg == 4'h0);

  // Host access recovery counter
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      recov_reg <= 4'h0;
    end else if (recov_reg != 4'h0) begin
      recov_reg <= recov_reg - 4'h1;
    end else if (io_hit && (io_req.wr || io_req.rd) &&
                 io_req.src == dmaa_pkg::SRC_HOST) begin
      recov_reg <= 4'(dmaa_pkg::IO_RECOVERY_CYC);
    end
  end

  // Bus role outputs
  always_comb begin
    bus_owned = arb_master;
    refresh_active = arb_master && refresh_cycle;
    inta_ack = !arb_master && inta_cycle;
  end

  // Read data of the selected register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= dmaa_pkg::RESET_BYTE;
    end else if (acc_rd) begin
      case (acc_fld)
        dmaa_pkg::FLD_ADDR_LO: rdata_reg <= cur_addr_reg[acc_chan][7:0];
        dmaa_pkg::FLD_ADDR_HI: rdata_reg <= cur_addr_reg[acc_chan][15:8];
        dmaa_pkg::FLD_CNT_LO: rdata_reg <= cur_cnt_reg[acc_chan][7:0];
        dmaa_pkg::FLD_CNT_MID: rdata_reg <= cur_cnt_reg[acc_chan][15:8];
        dmaa_pkg::FLD_CNT_HI: rdata_reg <= cur_cnt_reg[acc_chan][23:16];
        dmaa_pkg::FLD_PAGE_LO: rdata_reg <= cur_lpage_reg[acc_chan];
        dmaa_pkg::FLD_PAGE_HI: rdata_reg <= cur_hpage_reg[acc_chan];
        dmaa_pkg::FLD_STOP_0: rdata_reg <= {stop_reg[acc_chan][5:0], 2'b00};
        dmaa_pkg::FLD_STOP_1: rdata_reg <= stop_reg[acc_chan][13:6];
        dmaa_pkg::FLD_STOP_2: rdata_reg <= stop_reg[acc_chan][21:14];
        dmaa_pkg::FLD_CFG: rdata_reg <= cfg_reg[acc_chan];
        default: rdata_reg <= dmaa_pkg::RESET_BYTE;
      endcase
    end
  end

  // Transfer stepping, reload and register programming
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NC; i++) begin
        cur_addr_reg[i] <= 16'h0000;
        base_addr_reg[i] <= 16'h0000;
        cur_cnt_reg[i] <= 24'h000000;
        base_cnt_reg[i] <= 24'h000000;
        cur_lpage_reg[i] <= dmaa_pkg::RESET_BYTE;
        base_lpage_reg[i] <= dmaa_pkg::RESET_BYTE;
        cur_hpage_reg[i] <= dmaa_pkg::RESET_BYTE;
        base_hpage_reg[i] <= dmaa_pkg::RESET_BYTE;
        stop_reg[i] <= 22'h000000;
        cfg_reg[i] <= dmaa_pkg::RESET_BYTE;
      end
    end else begin
      // DMA cycle only when not refreshing
      if (arb_master && !refresh_cycle && xfer_go &&
          !stopped_reg[xfer_chan]) begin : xfer
        logic [31:0] nxt;
        logic tc;
        nxt = step_addr(full_addr(cur_hpage_reg[xfer_chan],
                                  cur_lpage_reg[xfer_chan],
                                  cur_addr_reg[xfer_chan]),
                        cfg_reg[xfer_chan][dmaa_pkg::CFG_DECR_BIT],
                        cfg_reg[xfer_chan][dmaa_pkg::CFG_SIZE_LSB +: 2],
                        ext_mode_reg[xfer_chan]);
        tc = (cur_cnt_reg[xfer_chan] == 24'h000000);
        if ((tc || end_of_process_marker) &&
            cfg_reg[xfer_chan][dmaa_pkg::CFG_AUTOINIT_BIT]) begin
          cur_addr_reg[xfer_chan] <= base_addr_reg[xfer_chan];
          cur_cnt_reg[xfer_chan] <= base_cnt_reg[xfer_chan];
          cur_lpage_reg[xfer_chan] <= base_lpage_reg[xfer_chan];
          cur_hpage_reg[xfer_chan] <= base_hpage_reg[xfer_chan];
        end else begin
          cur_addr_reg[xfer_chan] <= nxt[15:0];
          cur_lpage_reg[xfer_chan] <= nxt[23:16];
          cur_hpage_reg[xfer_chan] <= nxt[31:24];
          cur_cnt_reg[xfer_chan] <= cur_cnt_reg[xfer_chan] - 24'h000001;
        end
      end
      // Programming wins over a same-cycle transfer
      if (acc_wr) begin
        case (acc_fld)
          dmaa_pkg::FLD_ADDR_LO: begin
            cur_addr_reg[acc_chan][7:0] <= io_req.wdata;
            base_addr_reg[acc_chan][7:0] <= io_req.wdata;
          end
          dmaa_pkg::FLD_ADDR_HI: begin
            cur_addr_reg[acc_chan][15:8] <= io_req.wdata;
            base_addr_reg[acc_chan][15:8] <= io_req.wdata;
          end
          // Low and middle count bytes clear the high byte
          dmaa_pkg::FLD_CNT_LO: begin
            cur_cnt_reg[acc_chan] <= {8'h00, cur_cnt_reg[acc_chan][15:8],
                                      io_req.wdata};
            base_cnt_reg[acc_chan] <= {8'h00, base_cnt_reg[acc_chan][15:8],
                                       io_req.wdata};
          end
          dmaa_pkg::FLD_CNT_MID: begin
            cur_cnt_reg[acc_chan] <= {8'h00, io_req.wdata,
                                      cur_cnt_reg[acc_chan][7:0]};
            base_cnt_reg[acc_chan] <= {8'h00, io_req.wdata,
                                       base_cnt_reg[acc_chan][7:0]};
          end
          dmaa_pkg::FLD_CNT_HI: begin
            cur_cnt_reg[acc_chan][23:16] <= io_req.wdata;
            base_cnt_reg[acc_chan][23:16] <= io_req.wdata;
          end
          dmaa_pkg::FLD_PAGE_LO: begin
            cur_lpage_reg[acc_chan] <= io_req.wdata;
            base_lpage_reg[acc_chan] <= io_req.wdata;
          end
          dmaa_pkg::FLD_PAGE_HI: begin
            cur_hpage_reg[acc_chan] <= io_req.wdata;
            base_hpage_reg[acc_chan] <= io_req.wdata;
          end
          dmaa_pkg::FLD_STOP_0: stop_reg[acc_chan][5:0] <= io_req.wdata[7:2];
          dmaa_pkg::FLD_STOP_1: stop_reg[acc_chan][13:6] <= io_req.wdata;
          dmaa_pkg::FLD_STOP_2: stop_reg[acc_chan][21:14] <= io_req.wdata;
          dmaa_pkg::FLD_CFG: cfg_reg[acc_chan] <= io_req.wdata;
          default: ;
        endcase
        if (acc_fld == dmaa_pkg::FLD_ADDR_LO ||
            acc_fld == dmaa_pkg::FLD_ADDR_HI ||
            acc_fld == dmaa_pkg::FLD_PAGE_LO) begin
          cur_hpage_reg[acc_chan] <= dmaa_pkg::HIGH_PAGE_CLEAR;
          base_hpage_reg[acc_chan] <= dmaa_pkg::HIGH_PAGE_CLEAR;
        end
      end
    end
  end

  // Address mode flip-flops
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_mode_reg <= 8'h00;
    end else if (master_clear) begin
      ext_mode_reg <= 8'h00;
    end else if (acc_wr) begin
      if (acc_fld == dmaa_pkg::FLD_PAGE_HI) begin
        ext_mode_reg[acc_chan] <= 1'b1;
      end else if (acc_fld == dmaa_pkg::FLD_ADDR_LO ||
                   acc_fld == dmaa_pkg::FLD_ADDR_HI ||
                   acc_fld == dmaa_pkg::FLD_PAGE_LO) begin
        ext_mode_reg[acc_chan] <= 1'b0;
      end
    end
  end

  // Transfer result, terminal count, stop match and masking
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      xfer_reg <= '0;
      mask_reg <= 8'h00;
      stopped_reg <= 8'h00;
    end else begin
      xfer_reg.valid <= 1'b0;
      xfer_reg.tc <= 1'b0;
      mask_reg <= 8'h00;
      if (acc_wr && (acc_fld == dmaa_pkg::FLD_STOP_0 ||
                     acc_fld == dmaa_pkg::FLD_STOP_1 ||
                     acc_fld == dmaa_pkg::FLD_STOP_2)) begin
        stopped_reg[acc_chan] <= 1'b0;
      end
      if (arb_master && !refresh_cycle && xfer_go &&
          !stopped_reg[xfer_chan]) begin : res
        logic [31:0] a;
        logic tc;
        logic hit;
        a = full_addr(cur_hpage_reg[xfer_chan], cur_lpage_reg[xfer_chan],
                      cur_addr_reg[xfer_chan]);
        tc = (cur_cnt_reg[xfer_chan] == 24'h000000);
        hit = cfg_reg[xfer_chan][dmaa_pkg::CFG_STOP_EN_BIT] &&
              (a[23:2] == stop_reg[xfer_chan]);
        xfer_reg.valid <= 1'b1;
        xfer_reg.chan <= xfer_chan;
        xfer_reg.addr <= a;
        xfer_reg.tc <= tc;
        xfer_reg.mem_cmd_en <= !ext_mode_reg[xfer_chan] ||
                               (a[31:24] == dmaa_pkg::MEM_CMD_TOP_BYTE);
        if (hit) begin
          mask_reg[xfer_chan] <= 1'b1;
          stopped_reg[xfer_chan] <= 1'b1;
        end else if ((tc || end_of_process_marker) &&
                     !cfg_reg[xfer_chan][dmaa_pkg::CFG_AUTOINIT_BIT]) begin
          mask_reg[xfer_chan] <= 1'b1;
        end
      end
    end
  end

  // Output drive
  assign xfer_out = xfer_reg;
  assign mask_set = mask_reg;
  assign io_rdata = rdata_reg;
  assign ext_mode = ext_mode_reg;

endmodule : dmaa_channel_addr

`default_nettype wire

/* File: dmaa_pkg.sv */
// Constants and carrier types for the DMA address and reload block
package dmaa_pkg;

  // Channel count and register widths
  localparam int NUM_CHAN = 8;
  localparam int CHAN_W = 3;
  localparam int COUNT_W = 24;
  localparam int STOP_W = 22;

  // Register window base and channel stride in I/O space
  localparam logic [15:0] REG_BASE = 16'h0000;
  localparam int CHAN_SHIFT = 4;

  // Field index of each byte register within a channel window
  localparam logic [3:0] FLD_ADDR_LO = 4'h0;
  localparam logic [3:0] FLD_ADDR_HI = 4'h1;
  localparam logic [3:0] FLD_CNT_LO = 4'h2;
  localparam logic [3:0] FLD_CNT_MID = 4'h3;
  localparam logic [3:0] FLD_CNT_HI = 4'h4;
  localparam logic [3:0] FLD_PAGE_LO = 4'h5;
  localparam logic [3:0] FLD_PAGE_HI = 4'h6;
  localparam logic [3:0] FLD_STOP_0 = 4'h7;
  localparam logic [3:0] FLD_STOP_1 = 4'h8;
  localparam logic [3:0] FLD_STOP_2 = 4'h9;
  localparam logic [3:0] FLD_CFG = 4'hA;

  // Bit positions inside the channel configuration byte
  localparam int CFG_AUTOINIT_BIT = 0;
  localparam int CFG_STOP_EN_BIT = 1;
  localparam int CFG_DECR_BIT = 2;
  localparam int CFG_SIZE_LSB = 3;

  // Ranges closed to ISA masters
  localparam logic [15:0] ISA_CLOSED0_LO = 16'h0000;
  localparam logic [15:0] ISA_CLOSED0_HI = 16'h000F;
  localparam logic [15:0] ISA_CLOSED1_LO = 16'h00C0;
  localparam logic [15:0] ISA_CLOSED1_HI = 16'h00DF;

  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] HIGH_PAGE_CLEAR = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_EXPIRED = 24'hFFFFFF;

  // Memory commands only below this address in extended mode
  localparam logic [7:0] MEM_CMD_TOP_BYTE = 8'h00;

  // Recovery between back-to-back host accesses to 8-bit I/O
  localparam int CLK_PERIOD_PS = 8000;
  localparam int IO_RECOVERY_NS = 1;
  localparam int IO_RECOVERY_CYC_RAW =
    (IO_RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int IO_RECOVERY_CYC =
    (IO_RECOVERY_CYC_RAW < 1) ? 1 : IO_RECOVERY_CYC_RAW;

  // Who is driving the register access
  typedef enum logic [1:0] {
    SRC_HOST,
    SRC_EISA,
    SRC_ISA
  } dmaa_src_type;

  // Transfer element size
  typedef enum logic [1:0] {
    SIZE_BYTE,
    SIZE_WORD,
    SIZE_DWORD
  } dmaa_size_type;

  // One register access from the system bus
  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    dmaa_src_type src;
  } dmaa_io_req_type;

  // One generated DMA transfer
  typedef struct packed {
    logic valid;
    logic [CHAN_W-1:0] chan;
    logic [31:0] addr;
    logic mem_cmd_en;
    logic tc;
  } dmaa_xfer_type;

endpackage : dmaa_pkg

/* File: dmaa_props.sv */
// Port assertions for the DMA address and reload block
`timescale 1ns/100ps
`default_nettype none
module dmaa_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic master_clear,
  // Register access
  input var dmaa_pkg::dmaa_io_req_type io_req,
  input wire logic io_ready,
  input wire logic io_hit,
  input wire logic [7:0] io_rdata,
  // Bus role
  input wire logic isa_grant,
  input wire logic arb_master,
  input wire logic refresh_cycle,
  input wire logic inta_cycle,
  input wire logic inta_ack,
  input wire logic bus_owned,
  input wire logic refresh_active,
  // Transfers
  input wire logic xfer_go,
  input wire logic [2:0] xfer_chan,
  input wire logic end_of_process_marker,
  input var dmaa_pkg::dmaa_xfer_type xfer_out,
  input wire logic [7:0] mask_set,
  input wire logic [7:0] ext_mode
);
  // Write taken, its channel and field
  logic take_wr;
  logic [2:0] wr_ch;
  logic [3:0] fld;
  assign take_wr = io_hit && io_ready && io_req.wr;
  assign wr_ch = io_req.addr[6:4];
  assign fld = io_req.addr[3:0];

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Host access taken by the block
  sequence s_host_take;
    io_hit && io_ready && (io_req.wr || io_req.rd) &&
      io_req.src == dmaa_pkg::SRC_HOST;
  endsequence
  // High page write taken
  sequence s_hipage_wr;
    take_wr && fld == dmaa_pkg::FLD_PAGE_HI;
  endsequence

  a_inta_answer: assert property (
    inta_ack == (!arb_master && inta_cycle)) else $error("bad inta_ack");
  a_master_nodecode: assert property (
    arb_master |-> !io_hit) else $error("decode in master mode");
  a_isa_closed: assert property (
    isa_grant && io_req.src == dmaa_pkg::SRC_ISA &&
    (io_req.addr <= dmaa_pkg::ISA_CLOSED0_HI ||
     (io_req.addr >= dmaa_pkg::ISA_CLOSED1_LO &&
      io_req.addr <= dmaa_pkg::ISA_CLOSED1_HI)) |-> !io_hit)
    else $error("ISA reached closed range");
  a_master_owns: assert property (
    bus_owned == arb_master && refresh_active == (arb_master && refresh_cycle))
    else $error("bad bus role");
  a_xfer_cause: assert property (
    xfer_out.valid |-> $past(xfer_go && arb_master && !refresh_cycle) &&
      xfer_out.chan == $past(xfer_chan)) else $error("transfer without go");
  a_host_recovery: assert property (
    s_host_take |=> !io_ready) else $error("no recovery");
  // high page write sets extended mode
  a_hipage_ext: assert property (
    s_hipage_wr |=> ext_mode[$past(wr_ch)]) else $error("no extended mode");
  a_low_compat: assert property (
    take_wr && (fld == dmaa_pkg::FLD_ADDR_LO || fld == dmaa_pkg::FLD_ADDR_HI
      || fld == dmaa_pkg::FLD_PAGE_LO) |=> !ext_mode[$past(wr_ch)])
    else $error("still extended");
  a_mclear_compat: assert property (
    master_clear && !take_wr |=> ext_mode == 8'h00) else $error("mode kept");
  a_mem_cmd: assert property (
    xfer_out.valid |-> xfer_out.mem_cmd_en ==
      (xfer_out.addr[31:24] == dmaa_pkg::MEM_CMD_TOP_BYTE))
    else $error("bad mem_cmd_en");
  a_mask_cause: assert property (
    mask_set != 8'h00 |-> xfer_out.valid &&
      mask_set == (8'h01 << xfer_out.chan)) else $error("stray mask");
endmodule : dmaa_props

bind dmaa_channel_addr dmaa_props u_props (.sys_clk, .reset_n,
  .master_clear, .io_req, .io_ready, .io_hit, .io_rdata, .isa_grant,
  .arb_master, .refresh_cycle, .inta_cycle, .inta_ack, .bus_owned,
  .refresh_active, .xfer_go, .xfer_chan, .end_of_process_marker, .xfer_out,
  .mask_set, .ext_mode);
`default_nettype wire

/* File: dmaa_host_model.sv */
// Host and bus master model making byte register accesses
`timescale 1ns/100ps
`default_nettype none
module dmaa_host_model (
  // Clock
  input wire logic sys_clk,
  // Register access to the block
  output var dmaa_pkg::dmaa_io_req_type io_req,
  input wire logic io_ready,
  input wire logic io_hit,
  input wire logic [7:0] io_rdata
);
  // Idle bus until the first access
  initial io_req = '0;

  // One byte access, held until an edge with ready high
  // byte wide, idle cycle after
  task automatic access(input dmaa_pkg::dmaa_src_type src,
    input logic [15:0] a, input logic w, input logic [7:0] d,
    output logic hit, output logic [7:0] rdata);
    int n;
    n = 0;
    @(negedge sys_clk);
    io_req <= '{addr: a, wr: w, rd: !w, wdata: d, src: src};
    #1;
    // Bounded wait for recovery to end
    while (io_ready !== 1'b1 && n < 8) begin
      n++;
      @(negedge sys_clk);
      #1;
    end
    hit = io_hit;
    @(negedge sys_clk);
    rdata = io_rdata;
    // Released lines show the inverse, not the last value
    io_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d, src: src};
  endtask : access
endmodule : dmaa_host_model
`default_nettype wire

/* File: dma_channel_addr_autoinit_stop_tb_top.sv */
// Self-checking testbench for the DMA address and reload block
`timescale 1ns/100ps
`default_nettype none
module dma_channel_addr_autoinit_stop_tb_top;
  // Inputs driven by the bench
  logic sys_clk;
  logic reset_n;
  logic master_clear;
  logic isa_grant;
  logic arb_master;
  logic refresh_cycle;
  logic inta_cycle;
  logic xfer_go;
  logic [2:0] xfer_chan;
  logic end_of_process_marker;
  dmaa_pkg::dmaa_io_req_type io_req;
  // Block outputs
  logic io_ready;
  logic io_hit;
  logic [7:0] io_rdata;
  logic inta_ack;
  logic bus_owned;
  logic refresh_active;
  dmaa_pkg::dmaa_xfer_type xfer_out;
  logic [7:0] mask_set;
  logic [7:0] ext_mode;
  // Counters
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;

  dmaa_channel_addr DUT (.sys_clk, .reset_n, .master_clear, .io_req,
    .io_ready, .io_hit, .io_rdata, .isa_grant, .arb_master, .refresh_cycle,
    .inta_cycle, .inta_ack, .bus_owned, .refresh_active, .xfer_go,
    .xfer_chan, .end_of_process_marker, .xfer_out, .mask_set, .ext_mode);
  dmaa_host_model host (.sys_clk, .io_req, .io_ready, .io_hit, .io_rdata);

  // Clock at 125 MHz
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // Cut a hung run short
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      final_report();
    end
  end

  // Compare one value
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // Access with expected decode
  task automatic acc(input dmaa_pkg::dmaa_src_type s, input logic [15:0] a,
    input logic w, input logic [7:0] d, input logic eh);
    logic h;
    logic [7:0] r;
    host.access(s, a, w, d, h, r);
    check(h, eh);
  endtask : acc

  // Host byte write to a channel field
  task automatic wr(input logic [2:0] ch, input logic [3:0] f,
    input logic [7:0] d);
    acc(dmaa_pkg::SRC_HOST, dmaa_pkg::REG_BASE | {9'h000, ch, f}, 1'b1, d,
      1'b1);
  endtask : wr

  // Host byte read and compare
  task automatic rd(input logic [2:0] ch, input logic [3:0] f,
    input logic [7:0] exp);
    logic h;
    logic [7:0] r;
    host.access(dmaa_pkg::SRC_HOST, dmaa_pkg::REG_BASE | {9'h000, ch, f},
      1'b0, 8'h00, h, r);
    check(r, exp);
  endtask : rd

  // Bus role and ISA grant
  task automatic role(input logic m, input logic g);
    @(negedge sys_clk);
    arb_master <= m;
    isa_grant <= g;
    #1;
  endtask : role

  // One transfer request and its answer
  task automatic xfer(input logic [2:0] ch, input logic v,
    input logic [31:0] a, input logic tc, input logic m);
    @(negedge sys_clk);
    xfer_go <= 1'b1;
    xfer_chan <= ch;
    @(negedge sys_clk);
    xfer_go <= 1'b0;
    check(xfer_out.valid, v);
    check(mask_set[ch], m);
    if (v) begin
      check(xfer_out.addr, a);
      check(xfer_out.tc, tc);
    end
  endtask : xfer

  // Program a channel with transfers held off
  // slave mode, page then address
  task automatic setup(input logic [2:0] ch, input logic [7:0] cfg,
    input logic [15:0] a, input logic [7:0] lp, input logic [15:0] cnt);
    role(1'b0, 1'b0);
    wr(ch, dmaa_pkg::FLD_CFG, cfg);
    wr(ch, dmaa_pkg::FLD_PAGE_LO, lp);
    wr(ch, dmaa_pkg::FLD_ADDR_LO, a[7:0]);
    wr(ch, dmaa_pkg::FLD_ADDR_HI, a[15:8]);
    wr(ch, dmaa_pkg::FLD_CNT_LO, cnt[7:0]);
    wr(ch, dmaa_pkg::FLD_CNT_MID, cnt[15:8]);
  endtask : setup

  // State after reset
  task automatic t_reset();
    check(ext_mode, 8'h00);
    check(io_ready, 1'b1);
    check(xfer_out.valid, 1'b0);
    rd(0, dmaa_pkg::FLD_PAGE_HI, 8'h00);
  endtask : t_reset

  // Page registers and address modes
  task automatic t_pages();
    wr(2, dmaa_pkg::FLD_PAGE_LO, 8'h5A);
    wr(2, dmaa_pkg::FLD_PAGE_HI, 8'hA5);
    check(ext_mode[2], 1'b1);
    rd(2, dmaa_pkg::FLD_PAGE_LO, 8'h5A);
    rd(2, dmaa_pkg::FLD_PAGE_HI, 8'hA5);
    wr(2, dmaa_pkg::FLD_ADDR_HI, 8'h00);
    check(ext_mode[2], 1'b0);
    rd(2, dmaa_pkg::FLD_PAGE_HI, 8'h00);
    wr(2, dmaa_pkg::FLD_PAGE_HI, 8'hA5);
    @(negedge sys_clk);
    master_clear <= 1'b1;
    @(negedge sys_clk);
    master_clear <= 1'b0;
    check(ext_mode, 8'h00);
  endtask : t_pages

  // Autoinit reload in extended mode above 16M
  task automatic t_autoinit();
    setup(1, 8'h01, 16'h0010, 8'h03, 16'h0001);
    wr(1, dmaa_pkg::FLD_PAGE_HI, 8'h01);
    role(1'b1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      xfer(1, 1'b1, 32'h01030010 + i % 2, i[0], 1'b0);
    end
    // End of process reloads before the count runs out
    end_of_process_marker <= 1'b1;
    xfer(1, 1'b1, 32'h01030010, 1'b0, 1'b0);
    end_of_process_marker <= 1'b0;
    role(1'b0, 1'b0);
    rd(1, dmaa_pkg::FLD_ADDR_LO, 8'h10);
    rd(1, dmaa_pkg::FLD_PAGE_LO, 8'h03);
    rd(1, dmaa_pkg::FLD_PAGE_HI, 8'h01);
  endtask : t_autoinit

  // Compatibility mode wrap and end of count
  task automatic t_compat();
    setup(3, 8'h00, 16'hFFFF, 8'h07, 16'h0001);
    role(1'b1, 1'b0);
    xfer(3, 1'b1, 32'h0007FFFF, 1'b0, 1'b0);
    xfer(3, 1'b1, 32'h00070000, 1'b1, 1'b1);
  endtask : t_compat

  // Stop limit while counting down
  task automatic t_stop();
    setup(4, 8'h06, 16'h0021, 8'h00, 16'h00FF);
    // stop bytes hold A23 to A2
    wr(4, dmaa_pkg::FLD_STOP_0, 8'h1C);
    wr(4, dmaa_pkg::FLD_STOP_1, 8'h00);
    wr(4, dmaa_pkg::FLD_STOP_2, 8'h00);
    role(1'b1, 1'b0);
    for (int i = 0; i < 3; i++) begin
      xfer(4, 1'b1, 32'h21 - i, 1'b0, i == 2);
    end
    xfer(4, 1'b0, 32'h0, 1'b0, 1'b0);
    role(1'b0, 1'b0);
    wr(4, dmaa_pkg::FLD_CFG, 8'h04);
    wr(4, dmaa_pkg::FLD_STOP_2, 8'h00);
    role(1'b1, 1'b0);
    xfer(4, 1'b1, 32'h1E, 1'b0, 1'b0);
  endtask : t_stop

  // Slave decode, ISA limits, master mode
  task automatic t_roles();
    role(1'b0, 1'b1);
    acc(dmaa_pkg::SRC_ISA, 16'h0005, 1'b1, 8'h77, 1'b0);
    acc(dmaa_pkg::SRC_ISA, 16'h0025, 1'b1, 8'h66, 1'b1);
    acc(dmaa_pkg::SRC_EISA, 16'h0005, 1'b0, 8'h00, 1'b1);
    rd(2, dmaa_pkg::FLD_PAGE_LO, 8'h66);
    rd(0, dmaa_pkg::FLD_PAGE_LO, 8'h00);
    role(1'b1, 1'b0);
    acc(dmaa_pkg::SRC_HOST, 16'h0025, 1'b1, 8'h11, 1'b0);
    inta_cycle <= 1'b1;
    refresh_cycle <= 1'b1;
    #1;
    check(inta_ack, 1'b0);
    check(refresh_active, 1'b1);
    check(bus_owned, 1'b1);
    xfer(2, 1'b0, 32'h0, 1'b0, 1'b0);
    role(1'b0, 1'b0);
    check(inta_ack, 1'b1);
    @(negedge sys_clk);
    inta_cycle <= 1'b0;
    refresh_cycle <= 1'b0;
  endtask : t_roles

  // Main sequence
  initial begin
    reset_n = 1'b0;
    master_clear = 1'b0;
    isa_grant = 1'b0;
    arb_master = 1'b0;
    refresh_cycle = 1'b0;
    inta_cycle = 1'b0;
    xfer_go = 1'b0;
    xfer_chan = 3'h0;
    end_of_process_marker = 1'b0;
    repeat (6) @(negedge sys_clk);
    reset_n = 1'b1;
    t_reset();
    t_pages();
    t_autoinit();
    t_compat();
    t_stop();
    t_roles();
    final_report();
  end
endmodule : dma_channel_addr_autoinit_stop_tb_top
`default_nettype wire
